/* File: hdl/ref_regs_pkg.sv */
// shared constants and types for the timing-reference configuration registers
package ref_regs_pkg;

  // ****************************************
  // serial frame layout
  // ****************************************
  localparam int          FRAME_BITS    = 24;
  localparam int          HDR_BITS      = 16;
  localparam logic [4:0]  HDR_LAST_BIT  = 5'h0f;
  localparam logic [4:0]  FRAME_LAST    = 5'h17;
  localparam int          HDR_RW_POS    = 15;
  localparam int          ADDR_W        = 12;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [11:0] ADDR_REF_DELAY_CTRL_HI  = 12'h03c;
  localparam logic [11:0] ADDR_LANE_SWING_CTRL    = 12'h03d;
  localparam logic [11:0] ADDR_REF_SOFT_CTRL      = 12'h057;
  localparam logic [11:0] ADDR_SYNC_POLARITY_CTRL = 12'h058;
  localparam logic [11:0] ADDR_REF_DELAY_CTRL_LO  = 12'h05a;

  // ****************************************
  // field positions
  // ****************************************
  localparam int DEL_EN_POS     = 6;
  localparam int DEL_HI_MSB     = 1;
  localparam int DEL_HI_LSB     = 0;
  localparam int DEL_LO_MSB     = 7;
  localparam int DEL_LO_LSB     = 5;
  localparam int AMP_MSB        = 2;
  localparam int AMP_LSB        = 0;
  localparam int SRC_SEL_POS    = 3;
  localparam int SOFT_LVL_POS   = 4;
  localparam int SYNC_INV_POS   = 5;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ****************************************
  // delay and amplitude tables
  // ****************************************
  localparam logic [4:0] DELAY_FIRST_CODE = 5'h08;
  localparam logic [4:0] DELAY_LAST_CODE  = 5'h03;
  localparam logic [8:0] DELAY_FIRST_PS   = 9'h0af;
  localparam logic [8:0] DELAY_STEP_PS    = 9'h019;
  localparam logic [8:0] DELAY_NONE_PS    = 9'h000;

  localparam logic [9:0] SWING_0 = 10'h35c;
  localparam logic [9:0] SWING_1 = 10'h32a;
  localparam logic [9:0] SWING_2 = 10'h302;
  localparam logic [9:0] SWING_3 = 10'h2e9;
  localparam logic [9:0] SWING_4 = 10'h3c0;
  localparam logic [9:0] SWING_5 = 10'h3a2;
  localparam logic [9:0] SWING_6 = 10'h389;
  localparam logic [9:0] SWING_7 = 10'h370;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic sen_n;
    logic sclk;
    logic sdi;
  } spi_pins_t;

  typedef struct packed {
    logic       delay_enable;
    logic [4:0] delay_code;
    logic [8:0] delay_ps;
    logic [2:0] amplitude;
    logic [9:0] swing_mvpp;
  } ref_cfg_t;

endpackage

/* File: hdl/pin_sync3.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module pin_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin,
  output var  logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a bit moves only once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2[i] == s3[i]) begin
          level[i] <= s3[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

/* File: hdl/ref_cfg_regs.sv */
// serial-programmed timing-reference, sync polarity and lane swing registers
`timescale 1ns/1ns
`default_nettype none

// Operation
// - delay on timing reference applies only while delay enable is set
// - delay code: upper two bits from 0x3c[1:0], lower three from 0x5a[7:5]
// - code 01000 gives the first step, 175 ps total delay
// - each code step down to 00011 adds 25 ps, reaching 300 ps
// - amplitude code sets swing for all lanes; 0 is 860, 4 is 960 mVpp
// - source select 0 follows the pin, 1 follows the software level
// - with software source, level bit drives reference low or high
// - polarity bit 1 inverts the sync input before link logic uses it
// - every field reads zero after reset
module ref_cfg_regs (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire ref_regs_pkg::spi_pins_t spi,
  output var  logic                   sdo,
  output var  logic                   sdo_oe,
  input  wire logic                   timing_ref_pin,
  input  wire logic                   sync_n_pin,
  output var  logic                   timing_ref_int,
  output var  logic                   sync_link_n,
  output var  ref_regs_pkg::ref_cfg_t cfg
);
  import ref_regs_pkg::*;

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [8:0] delay_ps_of(input logic       en,
                                             input logic [4:0] code);
    logic [8:0] steps;
    steps = {4'h0, DELAY_FIRST_CODE - code};
    if (!en || code > DELAY_FIRST_CODE || code < DELAY_LAST_CODE) begin
      delay_ps_of = DELAY_NONE_PS;
    end else begin
      delay_ps_of = DELAY_FIRST_PS + 9'(steps * DELAY_STEP_PS);
    end
  endfunction

  function automatic logic [9:0] swing_of(input logic [2:0] amp);
    case (amp)
      3'h0:    swing_of = SWING_0;
      3'h1:    swing_of = SWING_1;
      3'h2:    swing_of = SWING_2;
      3'h3:    swing_of = SWING_3;
      3'h4:    swing_of = SWING_4;
      3'h5:    swing_of = SWING_5;
      3'h6:    swing_of = SWING_6;
      default: swing_of = SWING_7;
    endcase
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [4:0] pins_s;

  // active-low pins pass inverted so a cleared stage equals their idle level
  pin_sync3 #(.WIDTH(5)) u_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   ({~spi.sen_n, spi.sclk, spi.sdi, timing_ref_pin, ~sync_n_pin}),
    .level (pins_s)
  );

  logic sen_s;
  logic sync_s;
  logic sen_n_s;
  logic sclk_s;
  logic sdi_s;
  logic ref_s;
  logic sync_n_s;
  assign {sen_s, sclk_s, sdi_s, ref_s, sync_s} = pins_s;
  assign sen_n_s  = !sen_s;
  assign sync_n_s = !sync_s;

  // ****************************************
  // serial frame engine
  // ****************************************
  logic              sclk_prev;
  logic              sclk_rise;
  logic              sclk_fall;
  logic [4:0]        bit_cnt;
  logic [22:0]       shift_in;
  logic              rd_frame;
  logic              rd_phase;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        tx;
  logic              wr_fire;
  logic [7:0]        wr_data;

  assign sclk_rise = !sen_n_s && sclk_s && !sclk_prev;
  assign sclk_fall = !sen_n_s && !sclk_s && sclk_prev;
  assign wr_fire   = sclk_rise && bit_cnt == FRAME_LAST && !rd_frame;
  assign wr_data   = {shift_in[6:0], sdi_s};

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_s;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || sen_n_s) begin
      bit_cnt  <= '0;
      shift_in <= '0;
      rd_frame <= 1'b0;
      addr     <= '0;
    end else if (sclk_rise) begin
      shift_in <= {shift_in[21:0], sdi_s};
      if (bit_cnt != FRAME_LAST) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
      if (bit_cnt == HDR_LAST_BIT) begin
        rd_frame <= shift_in[HDR_RW_POS-1];
        addr     <= {shift_in[ADDR_W-2:0], sdi_s};
      end
    end
  end

  // ****************************************
  // configuration fields
  // ****************************************
  logic       del_en;
  logic [1:0] code_hi;
  logic [2:0] code_lo;
  logic [2:0] amp;
  logic       src_sel;
  logic       soft_lvl;
  logic       sync_inv;
  logic [4:0] code_now;

  assign code_now = {code_hi, code_lo};

  // reserved positions are not stored, so they always read back zero
  always_ff @(posedge clk) begin
    if (rst) begin
      del_en   <= REG_RESET[DEL_EN_POS];
      code_hi  <= REG_RESET[DEL_HI_MSB:DEL_HI_LSB];
      code_lo  <= REG_RESET[DEL_LO_MSB:DEL_LO_LSB];
      amp      <= REG_RESET[AMP_MSB:AMP_LSB];
      src_sel  <= REG_RESET[SRC_SEL_POS];
      soft_lvl <= REG_RESET[SOFT_LVL_POS];
      sync_inv <= REG_RESET[SYNC_INV_POS];
    end else if (wr_fire) begin
      case (addr)
        ADDR_REF_DELAY_CTRL_HI: begin
          del_en  <= wr_data[DEL_EN_POS];
          code_hi <= wr_data[DEL_HI_MSB:DEL_HI_LSB];
        end
        ADDR_REF_DELAY_CTRL_LO: begin
          code_lo <= wr_data[DEL_LO_MSB:DEL_LO_LSB];
        end
        ADDR_LANE_SWING_CTRL: begin
          amp <= wr_data[AMP_MSB:AMP_LSB];
        end
        ADDR_REF_SOFT_CTRL: begin
          src_sel  <= wr_data[SRC_SEL_POS];
          soft_lvl <= wr_data[SOFT_LVL_POS];
        end
        ADDR_SYNC_POLARITY_CTRL: begin
          sync_inv <= wr_data[SYNC_INV_POS];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // read-back path
  // ****************************************
  logic [7:0] rd_word;

  always_comb begin
    rd_word = 8'h00;
    case (addr)
      ADDR_REF_DELAY_CTRL_HI: begin
        rd_word[DEL_EN_POS]            = del_en;
        rd_word[DEL_HI_MSB:DEL_HI_LSB] = code_hi;
      end
      ADDR_REF_DELAY_CTRL_LO: rd_word[DEL_LO_MSB:DEL_LO_LSB] = code_lo;
      ADDR_LANE_SWING_CTRL:   rd_word[AMP_MSB:AMP_LSB]       = amp;
      ADDR_REF_SOFT_CTRL: begin
        rd_word[SRC_SEL_POS]  = src_sel;
        rd_word[SOFT_LVL_POS] = soft_lvl;
      end
      ADDR_SYNC_POLARITY_CTRL: rd_word[SYNC_INV_POS] = sync_inv;
      default: rd_word = 8'h00;
    endcase
  end

  // data word is captured one cycle after the header so addr is settled
  logic hdr_done;

  always_ff @(posedge clk) begin
    if (rst || sen_n_s) begin
      hdr_done <= 1'b0;
      rd_phase <= 1'b0;
      tx       <= '0;
    end else begin
      hdr_done <= sclk_rise && bit_cnt == HDR_LAST_BIT;
      if (hdr_done && rd_frame) begin
        rd_phase <= 1'b1;
        tx       <= rd_word;
      end else if (sclk_fall && rd_phase) begin
        tx <= {tx[6:0], 1'b0};
      end
    end
  end

  // sdo changes after a falling sclk so the host samples it on the rise
  always_ff @(posedge clk) begin
    if (rst || sen_n_s) begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (sclk_fall && rd_phase) begin
      sdo    <= tx[7];
      sdo_oe <= 1'b1;
    end
  end

  // ****************************************
  // block outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      timing_ref_int <= 1'b0;
      sync_link_n    <= 1'b0;
    end else begin
      timing_ref_int <= src_sel ? soft_lvl : ref_s;
      sync_link_n    <= sync_n_s ^ sync_inv;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= '0;
    end else begin
      cfg.delay_enable <= del_en;
      cfg.delay_code   <= code_now;
      cfg.delay_ps     <= delay_ps_of(del_en, code_now);
      cfg.amplitude    <= amp;
      cfg.swing_mvpp   <= swing_of(amp);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_DELAY_BYPASS: assert property (
    !del_en |=> !cfg.delay_enable && cfg.delay_ps == DELAY_NONE_PS)
    else $error("delay not bypassed while disabled");

  AST_DELAY_CODE: assert property (
    wr_fire && addr == ADDR_REF_DELAY_CTRL_LO
      |=> ##1 cfg.delay_code == {code_hi, $past(wr_data[7:5], 2)})
    else $error("delay code low bits not taken from 0x5a");

  AST_DELAY_FIRST: assert property (
    del_en && code_now == 5'h08 |=> cfg.delay_ps == 9'h0af)
    else $error("first delay step is not 175 ps");

  AST_DELAY_LAST: assert property (
    del_en && code_now == 5'h03 |=> cfg.delay_ps == 9'h12c)
    else $error("last delay step is not 300 ps");

  AST_DELAY_MID: assert property (
    del_en && code_now == 5'h05 |=> cfg.delay_ps == 9'h0fa)
    else $error("code 00101 is not 250 ps");

  AST_SWING: assert property (
    (!rst && amp == 3'h0 |=> cfg.swing_mvpp == 10'h35c) and
    (!rst && amp == 3'h4 |=> cfg.swing_mvpp == 10'h3c0))
    else $error("swing code 0 or 4 mapped wrongly");

  AST_SRC_PIN: assert property (
    !src_sel |=> timing_ref_int == $past(ref_s))
    else $error("reference does not follow pin");

  AST_SRC_SOFT: assert property (
    src_sel ##1 src_sel [*2] |-> timing_ref_int == $past(soft_lvl))
    else $error("reference does not follow software level");

  AST_SYNC_POL: assert property (
    $changed(sync_inv) && $stable(sync_n_s) |=> $changed(sync_link_n))
    else $error("sync polarity change not seen at link");

  AST_RESET_ZERO: assert property (
    @(posedge clk) disable iff (1'b0)
    rst |=> code_now == 5'h00 && !del_en && !src_sel && !sync_inv
            && amp == 3'h0 && cfg == '0)
    else $error("fields not zero after reset");

  COV_READ: cover property (hdr_done && rd_frame ##[1:200] sdo_oe);
  COV_SOFT_PULSE: cover property (src_sel && !soft_lvl ##[1:1000] soft_lvl);
  COV_DELAY_ON: cover property (cfg.delay_ps == 9'h0af);
  COV_SYNC_INV: cover property (sync_inv && !sync_link_n);

endmodule

`default_nettype wire

/* File: bench/spi_host_model.sv */
// serial host that frames register reads and writes for the config block
`timescale 1ns/1ns
`default_nettype none

module spi_host_model (
  input  wire logic                    clk,
  input  wire logic                    sdo,
  input  wire logic                    sdo_oe,
  output var  ref_regs_pkg::spi_pins_t spi,
  output var  logic                    rd_valid,
  output var  logic [7:0]              rd_data
);
  import ref_regs_pkg::*;
  // each sclk phase well above the 6 clk minimum, to cover sync lag
  localparam int HALF = 10;

  initial begin
    spi = '{sen_n: 1'b1, default: 1'b0};
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end

  // ****************************************
  // one whole 24-bit frame, msb first
  // ****************************************
  task automatic frame(input logic rw, input logic [11:0] addr,
                       input logic [7:0] wd);
    logic [23:0] f;
    f = {rw, 3'h0, addr, wd};
    @(posedge clk);
    spi.sen_n <= 1'b0;
    for (int b = FRAME_BITS - 1; b >= 0; b--) begin
      spi.sdi <= f[b];
      repeat (HALF) @(posedge clk);
      if (b < FRAME_BITS - HDR_BITS) begin
        rd_data[b] <= sdo;
      end
      spi.sclk <= 1'b1;
      repeat (HALF) @(posedge clk);
      spi.sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    spi.sen_n <= 1'b1;
    // released data line must not keep the last bit
    spi.sdi <= ~f[0];
    rd_valid <= rw;
    @(posedge clk);
    rd_valid <= 1'b0;
    repeat (HALF) @(posedge clk);
  endtask
endmodule

`default_nettype wire

/* File: bench/sysref_sync_master_regs_bench.sv */
// self-checking bench for the timing-reference config registers
`timescale 1ns/1ns
`default_nettype none

module sysref_sync_master_regs_bench;
  import ref_regs_pkg::*;
  localparam logic [11:0] ADDRS [5] = '{ADDR_REF_DELAY_CTRL_HI,
    ADDR_LANE_SWING_CTRL, ADDR_REF_SOFT_CTRL, ADDR_SYNC_POLARITY_CTRL,
    ADDR_REF_DELAY_CTRL_LO};
  localparam logic [7:0]  MASKS [5] = '{8'h43, 8'h07, 8'h18, 8'h20, 8'he0};
  localparam int          SWING [8] = '{860, 810, 770, 745,
                                        960, 930, 905, 880};

  logic       clk, rst, ref_pin, sync_pin, sdo, sdo_oe;
  logic       ref_int, sync_n, rd_valid, en, p;
  logic [7:0] rd_data, d;
  logic [4:0] c;
  spi_pins_t  spi;
  ref_cfg_t   cfg;
  logic [7:0] exp_q [$];
  int         num_errors, samples_checked, cycles, seed, ps;

  ref_cfg_regs ref_cfg_regs_i (.clk(clk), .rst(rst), .spi(spi), .sdo(sdo),
    .sdo_oe(sdo_oe), .timing_ref_pin(ref_pin), .sync_n_pin(sync_pin),
    .timing_ref_int(ref_int), .sync_link_n(sync_n), .cfg(cfg));
  spi_host_model spi_host_model_i (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe),
    .spi(spi), .rd_valid(rd_valid), .rd_data(rd_data));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic check(input string n, input logic [9:0] x,
                       input logic [9:0] g);
    samples_checked++;
    if (g !== x) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    spi_host_model_i.frame(1'b0, a, v);
    repeat (8) @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    spi_host_model_i.frame(1'b1, a, 8'h00);
    check("sdo_oe", 10'h000, {9'h000, sdo_oe});
  endtask

  // oldest expected read value against each returned byte
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      check("rd_data", {2'b00, exp_q.pop_front()}, {2'b00, rd_data});
      check("sdo_oe", 10'h001, {9'h000, sdo_oe});
    end
  end

  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 60000) begin
      num_errors++;
      end_sim();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 82;
    rst = 1'b1;
    ref_pin = 1'b0;
    sync_pin = 1'b1;
    cycles = 0;
    num_errors = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (ADDRS[i]) rd(ADDRS[i], REG_RESET);
    rd(12'h123, 8'h00);
    check("delay_ps", 10'h000, {1'b0, cfg.delay_ps});
    $display("reset values done");
    foreach (ADDRS[i]) begin
      d = 8'($random(seed)) & MASKS[i];
      wr(ADDRS[i], d);
      rd(ADDRS[i], d);
    end
    wr(12'h123, 8'hff);
    rd(12'h123, 8'h00);
    $display("readback done");
    for (int i = 0; i < 12; i++) begin
      c = (i < 9) ? 5'(i + 1) : 5'($random(seed));
      en = (i != 4);
      wr(ADDR_REF_DELAY_CTRL_HI, {1'b0, en, 4'h0, c[4:3]});
      wr(ADDR_REF_DELAY_CTRL_LO, {c[2:0], 5'h00});
      ps = (en && c >= 3 && c <= 8) ? 175 + 25 * (8 - int'(c)) : 0;
      check("delay_code", {5'h00, c}, {5'h00, cfg.delay_code});
      check("delay_enable", {9'h000, en}, {9'h000, cfg.delay_enable});
      check("delay_ps", 10'(ps), {1'b0, cfg.delay_ps});
    end
    $display("delay done");
    for (int a = 0; a < 8; a++) begin
      wr(ADDR_LANE_SWING_CTRL, 8'(a));
      check("amplitude", 10'(a), {7'h00, cfg.amplitude});
      check("swing", 10'(SWING[a]), cfg.swing_mvpp);
    end
    $display("swing done");
    wr(ADDR_REF_SOFT_CTRL, 8'h10);
    for (int k = 0; k < 4; k++) begin
      ref_pin <= k[0];
      repeat (8) @(posedge clk);
      check("timing_ref_int", {9'h000, k[0]}, {9'h000, ref_int});
    end
    wr(ADDR_REF_SOFT_CTRL, 8'h08);
    ref_pin <= 1'b1;
    repeat (8) @(posedge clk);
    check("timing_ref_int", 10'h000, {9'h000, ref_int});
    wr(ADDR_REF_SOFT_CTRL, 8'h18);
    ref_pin <= 1'b0;
    repeat (8) @(posedge clk);
    check("timing_ref_int", 10'h001, {9'h000, ref_int});
    wr(ADDR_REF_SOFT_CTRL, 8'h00);
    $display("soft source done");
    for (int k = 0; k < 8; k++) begin
      if (k == 0 || k == 4) wr(ADDR_SYNC_POLARITY_CTRL, {2'b00, k[2], 5'h00});
      p = 1'($random(seed));
      sync_pin <= p;
      repeat (8) @(posedge clk);
      check("sync_link_n", {9'h000, p ^ k[2]}, {9'h000, sync_n});
    end
    wr(ADDR_SYNC_POLARITY_CTRL, 8'h00);
    $display("sync polarity done");
    end_sim();
  end
endmodule

`default_nettype wire
